// *** shared/tsc_defines.vh ***
/*
  Constants for the tile status and control register bank: register
  numbers, writable masks, field positions and fixed values.
  Assumes it is included by bare name from each design file that uses it.
*/
`ifndef TSC_DEFINES_VH
`define TSC_DEFINES_VH

// Register numbers
`define TSC_REG_TILE_CTRL      8'h02
`define TSC_REG_BOOT_STATUS    8'h03
`define TSC_REG_SECURITY       8'h05
`define TSC_REG_OSC_CTRL       8'h06
`define TSC_REG_OSC_COUNT0     8'h07
`define TSC_REG_OSC_COUNT1     8'h08
`define TSC_REG_OSC_COUNT2     8'h09
`define TSC_REG_OSC_COUNT3     8'h0a
`define TSC_REG_MEM_CAPACITY   8'h0c

// Writable bits and reset values
`define TSC_TILE_CTRL_MASK     32'h03ffff36
`define TSC_TILE_CTRL_RESET    32'h00000000
`define TSC_SECURITY_MASK      32'h80005fb1
`define TSC_SECURITY_RESET     32'h00000000
`define TSC_OSC_CTRL_MASK      32'h00000003
`define TSC_OSC_CTRL_RESET     32'h00000000

// Tile control fields
`define TSC_TC_DELAY_HI        25
`define TSC_TC_DELAY_LO        18
`define TSC_TC_DIV_HI          17
`define TSC_TC_DIV_LO          9
`define TSC_TC_PORT_EN_BIT     8
`define TSC_TC_DYNAMIC_BIT     5
`define TSC_TC_DIV_EN_BIT      4
`define TSC_TC_UTMI_SEL_BIT    2
`define TSC_TC_ULPI_EN_BIT     1

// Boot status fields
`define TSC_BS_PROC_HI         23
`define TSC_BS_PROC_LO         16
`define TSC_BS_OVERRIDE_BIT    8
`define TSC_BS_CORE1_OFF_BIT   5
`define TSC_BS_SKIP_POLL_BIT   4
`define TSC_BS_FROM_RAM_BIT    3
`define TSC_BS_FROM_JTAG_BIT   2
`define TSC_BS_PLL_HI          1
`define TSC_BS_PLL_LO          0

// Security fields
`define TSC_SEC_WRITE_LOCK_BIT 31
`define TSC_SEC_GLOBAL_DBG_BIT 14
`define TSC_SEC_LOCK_ALL_BIT   12
`define TSC_SEC_SECTOR_HI      11
`define TSC_SEC_SECTOR_LO      8
`define TSC_SEC_REDUNDANCY_BIT 7
`define TSC_SEC_OTP_BOOT_BIT   5
`define TSC_SEC_JTAG_CFG_BIT   4
`define TSC_SEC_JTAG_TAP_BIT   0

// Ring oscillator control fields
`define TSC_OSC_CORE_EN_BIT    1
`define TSC_OSC_PERIPH_EN_BIT  0

// Strap synchroniser fill: cycles until stage three holds a pin sample
`define TSC_STRAP_FILL         2'h3

// Memory capacity in bytes; bits 1:0 always read zero
`define TSC_MEM_CAPACITY_BYTES 32'h00010000

`endif

// *** verilog/tsc_ring_osc_counter.v ***
/*
  One ring oscillator counter: synchronises the oscillator output into
  the tile clock and counts its rising edges in 16 bits.
  Assumes porRst is a power-on reset only; the system reset never
  clears the count.
*/
`timescale 1ns/1ps
`default_nettype none

module tsc_ring_osc_counter (
  input  wire        clock,
  input  wire        porRst,
  input  wire        oscIn,
  output reg  [15:0] count_reg
);

  reg syncA_reg;
  reg syncB_reg;
  reg syncC_reg;
  reg level_reg;

  // Three stage synchroniser; a level counts once stages two and three agree
  always @(posedge clock) begin
    if (porRst) begin
      syncA_reg <= 1'b0;
      syncB_reg <= 1'b0;
      syncC_reg <= 1'b0;
      level_reg <= 1'b0;
      count_reg <= 16'h0000;
    end else begin
      syncA_reg <= oscIn;
      syncB_reg <= syncA_reg;
      syncC_reg <= syncB_reg;
      if (syncB_reg == syncC_reg) begin
        level_reg <= syncC_reg;
        if (syncC_reg && !level_reg) begin
          count_reg <= count_reg + 16'h0001;
        end
      end
    end
  end

endmodule // tsc_ring_osc_counter

`default_nettype wire

// *** verilog/tsc_tx_clock_gen.v ***
/*
  RGMII transmit clock divider and data launch delay.
  Assumes clock is the PLL output that the tile runs on.
*/
`timescale 1ns/1ps
`default_nettype none

module tsc_tx_clock_gen (
  input  wire       clock,
  input  wire       rst,
  input  wire       enable,
  input  wire [8:0] divider,
  input  wire [7:0] dataDelay,
  output reg        txClk_reg,
  output reg        txLaunch_reg
);

  reg [8:0] count_reg;
  reg [7:0] delay_reg;
  reg       pending_reg;

  always @(posedge clock) begin
    if (rst || !enable) begin
      count_reg    <= 9'h000;
      txClk_reg    <= 1'b0;
      delay_reg    <= 8'h00;
      pending_reg  <= 1'b0;
      txLaunch_reg <= 1'b0;
    end else begin
      // Counter wraps at the divider, or at once when a smaller divider was written
      if (count_reg >= divider) begin
        count_reg <= 9'h000;
      end else begin
        count_reg <= count_reg + 9'h001;
      end
      if (count_reg == divider) begin
        txClk_reg <= 1'b1;
      end else if (count_reg == (divider >> 1)) begin
        txClk_reg <= 1'b0;
      end
      // Data launch follows each rising edge by dataDelay plus one cycles
      txLaunch_reg <= 1'b0;
      if (count_reg == divider) begin
        pending_reg <= 1'b1;
        delay_reg   <= dataDelay;
      end else if (pending_reg) begin
        if (delay_reg == 8'h00) begin
          pending_reg  <= 1'b0;
          txLaunch_reg <= 1'b1;
        end else begin
          delay_reg <= delay_reg - 8'h01;
        end
      end
    end
  end

endmodule // tsc_tx_clock_gen

`default_nettype wire

// *** verilog/tsc_status_regs.v ***
/*
  Processor status register bank of one tile: tile control, boot
  status, security configuration, ring oscillator control and counts,
  memory capacity.
  Assumes one-cycle read and write strobes from the tile's processor on
  the same clock, and ring oscillator outputs arriving asynchronously.
*/
`timescale 1ns/1ps
`default_nettype none

`include "tsc_defines.vh"

module tsc_status_regs (
  input  wire        clock,
  input  wire        rst,
  input  wire        porRst,
  input  wire        psWriteEn,
  input  wire        psReadEn,
  input  wire [7:0]  psAddr,
  input  wire [31:0] psWriteData,
  output reg  [31:0] psReadData,
  output reg         psReadValid,
  output reg         psAccessError,
  input  wire [7:0]  processorNumber,
  input  wire [1:0]  bootPllModePin,
  input  wire        bootFromJtag,
  input  wire        bootFromRam,
  input  wire        core1PoweredOff,
  input  wire        skipOtpLevelPoll,
  input  wire        otpSecurityLoad,
  input  wire [31:0] otpSecurityWord,
  input  wire        allThreadsPaused,
  input  wire [3:0]  ringOscIn,
  output wire [3:0]  ringOscEnable,
  output wire        rgmiiTxClk,
  output wire        rgmiiTxLaunch,
  output wire        rgmiiPortsEnable,
  output reg         coreClkDivideActive,
  output wire        usbUtmiSelect,
  output wire        ulpiModuleEnable,
  output wire        otpLockAll,
  output wire [3:0]  otpSectorLock,
  output wire        otpRedundancyEnable,
  output wire        bootFromOtp,
  output wire        jtagConfigBlock,
  output wire        jtagTapBlock,
  output wire        globalDebugBlock
);

  reg  [31:0] tileCtrl_reg;
  reg  [31:0] tileCtrl_next;
  reg  [31:0] security_reg;
  reg  [31:0] security_next;
  reg  [31:0] oscCtrl_reg;
  reg  [31:0] oscCtrl_next;
  reg  [31:0] readData_next;
  reg         readKnown;
  reg         writeOk;
  reg  [1:0]  pllSyncA_reg;
  reg  [1:0]  pllSyncB_reg;
  reg  [1:0]  pllSyncC_reg;
  reg  [1:0]  pllStrap_reg;
  reg         strapTaken_reg;
  wire [31:0] bootStatus;
  wire [15:0] oscCount [0:3];
  wire        securityLocked;
  reg  [1:0]  strapFill_reg;
  reg         divideActive_next;
  wire [7:0]  txDataDelay;
  wire [8:0]  txDivider;

  // Tile control outputs
  assign rgmiiPortsEnable = tileCtrl_reg[`TSC_TC_PORT_EN_BIT];
  assign usbUtmiSelect    = tileCtrl_reg[`TSC_TC_UTMI_SEL_BIT];
  assign ulpiModuleEnable = tileCtrl_reg[`TSC_TC_ULPI_EN_BIT];
  assign txDataDelay      = tileCtrl_reg[`TSC_TC_DELAY_HI:`TSC_TC_DELAY_LO];
  assign txDivider        = tileCtrl_reg[`TSC_TC_DIV_HI:`TSC_TC_DIV_LO];

  // Security outputs
  assign securityLocked      = security_reg[`TSC_SEC_WRITE_LOCK_BIT];
  assign otpLockAll          = security_reg[`TSC_SEC_LOCK_ALL_BIT];
  assign otpSectorLock       =
    security_reg[`TSC_SEC_SECTOR_HI:`TSC_SEC_SECTOR_LO];
  assign otpRedundancyEnable = security_reg[`TSC_SEC_REDUNDANCY_BIT];
  assign bootFromOtp         = security_reg[`TSC_SEC_OTP_BOOT_BIT];
  assign jtagConfigBlock     = security_reg[`TSC_SEC_JTAG_CFG_BIT];
  assign jtagTapBlock        = security_reg[`TSC_SEC_JTAG_TAP_BIT];
  assign globalDebugBlock    = security_reg[`TSC_SEC_GLOBAL_DBG_BIT];

  // Oscillator enables: 0,1 tile cell and wire; 2,3 peripheral cell and wire
  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : oscEnables
      if (j < 2) begin : coreSide
        assign ringOscEnable[j] = oscCtrl_reg[`TSC_OSC_CORE_EN_BIT];
      end else begin : periphSide
        assign ringOscEnable[j] = oscCtrl_reg[`TSC_OSC_PERIPH_EN_BIT];
      end
    end
  endgenerate

  // Boot status word, reserved bits zero
  assign bootStatus = {
    8'h00,
    processorNumber,
    7'h00,
    security_reg[`TSC_SEC_OTP_BOOT_BIT],
    2'h0,
    core1PoweredOff,
    skipOtpLevelPoll,
    bootFromRam,
    bootFromJtag,
    pllStrap_reg
  };

  // Strap pins pass three flip-flops; the fill count waits for real samples in stage three
  always @(posedge clock) begin
    if (rst) begin
      pllSyncA_reg  <= 2'h0;
      pllSyncB_reg  <= 2'h0;
      pllSyncC_reg  <= 2'h0;
      strapFill_reg <= 2'h0;
    end else begin
      pllSyncA_reg <= bootPllModePin;
      pllSyncB_reg <= pllSyncA_reg;
      pllSyncC_reg <= pllSyncB_reg;
      if (strapFill_reg != `TSC_STRAP_FILL) begin
        strapFill_reg <= strapFill_reg + 2'h1;
      end
    end
  end

  // Strap value caught once after the fill, when stages two and three agree
  always @(posedge clock) begin
    if (rst) begin
      pllStrap_reg   <= 2'h0;
      strapTaken_reg <= 1'b0;
    end else begin
      if (!strapTaken_reg && (strapFill_reg == `TSC_STRAP_FILL) &&
          (pllSyncB_reg == pllSyncC_reg)) begin
        pllStrap_reg   <= pllSyncC_reg;
        strapTaken_reg <= 1'b1;
      end
    end
  end

  // Tile control next value
  always @* begin
    tileCtrl_next = tileCtrl_reg;
    if (psWriteEn && (psAddr == `TSC_REG_TILE_CTRL)) begin
      tileCtrl_next = psWriteData & `TSC_TILE_CTRL_MASK;
    end
  end

  // Security next value; the OTP copy wins over a software write in the same cycle
  always @* begin
    security_next = security_reg;
    if (otpSecurityLoad) begin
      security_next = otpSecurityWord & `TSC_SECURITY_MASK;
    end else if (psWriteEn && (psAddr == `TSC_REG_SECURITY) && !securityLocked) begin
      security_next = psWriteData & `TSC_SECURITY_MASK;
    end
  end

  // Oscillator control next value
  always @* begin
    oscCtrl_next = oscCtrl_reg;
    if (psWriteEn && (psAddr == `TSC_REG_OSC_CTRL)) begin
      oscCtrl_next = psWriteData & `TSC_OSC_CTRL_MASK;
    end
  end

  // Writes accepted: tile control, oscillator control, unlocked security
  always @* begin
    writeOk = 1'b0;
    case (psAddr)
      `TSC_REG_TILE_CTRL: begin
        writeOk = 1'b1;
      end
      `TSC_REG_SECURITY: begin
        writeOk = !securityLocked;
      end
      `TSC_REG_OSC_CTRL: begin
        writeOk = 1'b1;
      end
      default: begin
        writeOk = 1'b0;
      end
    endcase
  end

  // Read multiplexer
  always @* begin
    readData_next = 32'h00000000;
    readKnown     = 1'b1;
    case (psAddr)
      `TSC_REG_TILE_CTRL: begin
        readData_next = tileCtrl_reg;
      end
      `TSC_REG_BOOT_STATUS: begin
        readData_next = bootStatus;
      end
      `TSC_REG_SECURITY: begin
        readData_next = security_reg;
      end
      `TSC_REG_OSC_CTRL: begin
        readData_next = oscCtrl_reg;
      end
      `TSC_REG_OSC_COUNT0: begin
        readData_next = {16'h0000, oscCount[0]};
      end
      `TSC_REG_OSC_COUNT1: begin
        readData_next = {16'h0000, oscCount[1]};
      end
      `TSC_REG_OSC_COUNT2: begin
        readData_next = {16'h0000, oscCount[2]};
      end
      `TSC_REG_OSC_COUNT3: begin
        readData_next = {16'h0000, oscCount[3]};
      end
      `TSC_REG_MEM_CAPACITY: begin
        readData_next = `TSC_MEM_CAPACITY_BYTES & 32'hfffffffc;
      end
      default: begin
        readKnown = 1'b0;
      end
    endcase
  end

  // Tile control register
  always @(posedge clock) begin
    if (rst) begin
      tileCtrl_reg <= `TSC_TILE_CTRL_RESET;
    end else begin
      tileCtrl_reg <= tileCtrl_next;
    end
  end

  // Security configuration, clear until the OTP copy or a software write arrives
  always @(posedge clock) begin
    if (rst) begin
      security_reg <= `TSC_SECURITY_RESET;
    end else begin
      security_reg <= security_next;
    end
  end

  // Ring oscillator control register
  always @(posedge clock) begin
    if (rst) begin
      oscCtrl_reg <= `TSC_OSC_CTRL_RESET;
    end else begin
      oscCtrl_reg <= oscCtrl_next;
    end
  end

  // Read answer, one cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      psReadData  <= 32'h00000000;
      psReadValid <= 1'b0;
    end else begin
      psReadValid <= psReadEn;
      psReadData  <= psReadEn ? readData_next : 32'h00000000;
    end
  end

  // Refused access flag, one cycle after the strobe
  always @(posedge clock) begin
    if (rst) begin
      psAccessError <= 1'b0;
    end else begin
      psAccessError <= (psWriteEn && !writeOk) || (psReadEn && !readKnown);
    end
  end

  // Dynamic mode divides only while every active thread is paused
  always @* begin
    divideActive_next = 1'b0;
    if (tileCtrl_reg[`TSC_TC_DIV_EN_BIT]) begin
      if (tileCtrl_reg[`TSC_TC_DYNAMIC_BIT]) begin
        divideActive_next = allThreadsPaused;
      end else begin
        divideActive_next = 1'b1;
      end
    end
  end

  // Divide request is registered
  always @(posedge clock) begin
    if (rst) begin
      coreClkDivideActive <= 1'b0;
    end else begin
      coreClkDivideActive <= divideActive_next;
    end
  end

  // Transmit clock divider; divider field already holds ratio minus one
  tsc_tx_clock_gen txClockGen (
    .clock        (clock),
    .rst          (rst),
    .enable       (rgmiiPortsEnable),
    .divider      (txDivider),
    .dataDelay    (txDataDelay),
    .txClk_reg    (rgmiiTxClk),
    .txLaunch_reg (rgmiiTxLaunch)
  );

  // One counter per ring oscillator, cleared only by power-on reset
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : oscCounters
      tsc_ring_osc_counter oscCounter (
        .clock     (clock),
        .porRst    (porRst),
        .oscIn     (ringOscIn[i]),
        .count_reg (oscCount[i])
      );
    end
  endgenerate

endmodule // tsc_status_regs

`default_nettype wire

// *** testbench/tsc_status_regs_checker.sv ***
/* Checker for the tile status register bank: read answers and outputs.
   Assumes binding to tsc_status_regs; rst is synchronous, active high. */
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defines.vh"
module tsc_status_regs_checker (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        psWriteEn,
  input wire logic        psReadEn,
  input wire logic [7:0]  psAddr,
  input wire logic [31:0] psWriteData,
  input wire logic [31:0] psReadData,
  input wire logic        psReadValid,
  input wire logic [7:0]  processorNumber,
  input wire logic        bootFromJtag,
  input wire logic        bootFromRam,
  input wire logic        core1PoweredOff,
  input wire logic        skipOtpLevelPoll,
  input wire logic        otpSecurityLoad,
  input wire logic [31:0] otpSecurityWord,
  input wire logic [3:0]  ringOscEnable,
  input wire logic        rgmiiPortsEnable,
  input wire logic        usbUtmiSelect,
  input wire logic        ulpiModuleEnable,
  input wire logic        otpLockAll,
  input wire logic [3:0]  otpSectorLock,
  input wire logic        jtagTapBlock,
  input wire logic        globalDebugBlock
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_ports;
    psWriteEn && psAddr == 8'h02 |=> rgmiiPortsEnable == $past(psWriteData[8]);
  endproperty
  a_ports: assert property (p_ports) else $error("ports enable wrong");

  property p_usb;
    psWriteEn && psAddr == 8'h02 |=> usbUtmiSelect == $past(psWriteData[2])
      && ulpiModuleEnable == $past(psWriteData[1]);
  endproperty
  a_usb: assert property (p_usb) else $error("usb select wrong");

  property p_ctrl_rsv;
    psReadEn && psAddr == 8'h02 |=> (psReadData & ~`TSC_TILE_CTRL_MASK) == 32'h0;
  endproperty
  a_ctrl_rsv: assert property (p_ctrl_rsv) else $error("reserved bit set");

  property p_proc;
    psReadEn && psAddr == 8'h03 |=> psReadData[31:16] == {8'h00, $past(processorNumber)};
  endproperty
  a_proc: assert property (p_proc) else $error("processor number wrong");

  property p_boot;
    psReadEn && psAddr == 8'h03 |=> psReadData[5:2] == {$past(core1PoweredOff),
      $past(skipOtpLevelPoll), $past(bootFromRam), $past(bootFromJtag)};
  endproperty
  a_boot: assert property (p_boot) else $error("boot flags wrong");

  property p_count;
    psReadEn && psAddr >= 8'h07 && psAddr <= 8'h0a |=> ##0 psReadValid
      && psReadData[31:16] == 16'h0000;
  endproperty
  a_count: assert property (p_count) else $error("count upper bits set");

  property p_mem;
    psReadEn && psAddr == 8'h0c |=> psReadData == `TSC_MEM_CAPACITY_BYTES;
  endproperty
  a_mem: assert property (p_mem) else $error("capacity wrong");

  property p_lock;
    otpSecurityLoad |=> otpLockAll == $past(otpSecurityWord[12])
      && otpSectorLock == $past(otpSecurityWord[11:8]);
  endproperty
  a_lock: assert property (p_lock) else $error("sector lock wrong");

  property p_debug;
    otpSecurityLoad |=> jtagTapBlock == $past(otpSecurityWord[0])
      && globalDebugBlock == $past(otpSecurityWord[14]);
  endproperty
  a_debug: assert property (p_debug) else $error("debug block wrong");

  property p_osc;
    psWriteEn && psAddr == 8'h06 |=> ringOscEnable ==
      {{2{$past(psWriteData[0])}}, {2{$past(psWriteData[1])}}};
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
endmodule // tsc_status_regs_checker

bind tsc_status_regs tsc_status_regs_checker chk (.*);
`default_nettype wire

// *** testbench/tsc_status_regs_bench.sv ***
/* Bench for the tile status register bank: reads and writes with expected
   values. Assumes the checker file is compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module tsc_status_regs_bench;
  logic        clock = 0;
  logic        rst = 1;
  logic        porRst = 1;
  logic        psWriteEn = 0;
  logic        psReadEn = 0;
  logic [7:0]  psAddr = 0;
  logic [31:0] psWriteData = 0;
  logic [7:0]  processorNumber = 8'ha5;
  logic [1:0]  bootPllModePin = 2'h2;
  logic        bootFromJtag = 1;
  logic        bootFromRam = 0;
  logic        core1PoweredOff = 1;
  logic        skipOtpLevelPoll = 0;
  logic        otpSecurityLoad = 0;
  logic [31:0] otpSecurityWord = 0;
  logic        allThreadsPaused = 0;
  logic [3:0]  ringOscIn = 0;
  wire  [31:0] psReadData;
  wire  [3:0]  ringOscEnable, otpSectorLock;
  wire         psReadValid, psAccessError, rgmiiTxClk, rgmiiTxLaunch, rgmiiPortsEnable;
  wire         coreClkDivideActive, usbUtmiSelect, ulpiModuleEnable, otpLockAll;
  wire         otpRedundancyEnable, bootFromOtp, jtagConfigBlock, jtagTapBlock;
  wire         globalDebugBlock;
  wire  [9:0]  secOut = {otpLockAll, otpSectorLock, otpRedundancyEnable, bootFromOtp,
                         jtagConfigBlock, jtagTapBlock, globalDebugBlock};
  integer      n_fail = 0, compares = 0, i, k, h, l;

  tsc_status_regs uut (.*);

  always #20 clock = ~clock;

  task give_verdict;
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input [31:0] g, input [31:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task cyc(input integer n);
    repeat (n) @(negedge clock);
  endtask

  task wr(input [7:0] a, input [31:0] d, input e);
    @(negedge clock);
    psWriteEn = 1;
    psAddr = a;
    psWriteData = d;
    @(negedge clock);
    psWriteEn = 0;
    chk(psAccessError, e);
  endtask

  task rd(input [7:0] a, input [31:0] e, input er);
    @(negedge clock);
    psReadEn = 1;
    psAddr = a;
    @(negedge clock);
    psReadEn = 0;
    chk(psReadValid, 1);
    chk(psReadData, e);
    chk(psAccessError, er);
  endtask

  task run(input integer n, output integer hc, output integer lc);
    hc = 0;
    lc = 0;
    repeat (n) begin
      @(negedge clock);
      hc += rgmiiTxClk;
      lc += rgmiiTxLaunch;
    end
  endtask

  initial begin
    #400000;
    n_fail++;
    give_verdict;
  end

  initial begin
    cyc(10);
    rst = 0;
    porRst = 0;
    cyc(6);
    rd(8'h02, 32'h0, 0);
    rd(8'h06, 32'h0, 0);
    rd(8'h03, 32'h00a50026, 0);
    wr(8'h03, 32'hffffffff, 1);
    wr(8'h02, 32'hffffffff, 0);
    rd(8'h02, 32'h03ffff36, 0);
    chk({rgmiiPortsEnable, usbUtmiSelect, ulpiModuleEnable}, 3'h7);
    wr(8'h02, 32'h00000700, 0);
    cyc(8);
    run(16, h, l);
    chk(h, 8);
    chk(l, 4);
    wr(8'h02, 32'h000c0b00, 0);
    cyc(12);
    run(24, h, l);
    chk(h, 12);
    chk(l, 4);
    wr(8'h02, 32'h00000100, 0);
    cyc(4);
    run(8, h, l);
    chk(h, 8);
    wr(8'h02, 32'h00000010, 0);
    cyc(4);
    run(8, h, l);
    chk(h + l, 0);
    chk({rgmiiPortsEnable, usbUtmiSelect, ulpiModuleEnable}, 3'h0);
    chk(coreClkDivideActive, 1);
    wr(8'h02, 32'h00000030, 0);
    cyc(2);
    chk(coreClkDivideActive, 0);
    allThreadsPaused = 1;
    cyc(2);
    chk(coreClkDivideActive, 1);
    allThreadsPaused = 0;
    otpSecurityLoad = 1;
    otpSecurityWord = 32'h7fffffff;
    cyc(1);
    otpSecurityLoad = 0;
    chk(secOut, 10'h3ff);
    rd(8'h05, 32'h00005fb1, 0);
    processorNumber = 8'h3c;
    bootFromJtag = 0;
    bootFromRam = 1;
    core1PoweredOff = 0;
    skipOtpLevelPoll = 1;
    rd(8'h03, 32'h003c011a, 0);
    wr(8'h05, 32'h80000000, 0);
    chk(secOut, 10'h0);
    wr(8'h05, 32'h00000001, 1);
    rd(8'h05, 32'h80000000, 0);
    wr(8'h06, 32'h1, 0);
    chk(ringOscEnable, 4'hc);
    wr(8'h06, 32'h2, 0);
    chk(ringOscEnable, 4'h3);
    wr(8'h06, 32'hffffffff, 0);
    rd(8'h06, 32'h3, 0);
    for (k = 0; k < 40; k++) begin
      for (i = 0; i < 4; i++)
        if (k < 10 * (i + 1)) ringOscIn[i] = ~ringOscIn[i];
      cyc(4);
    end
    wr(8'h06, 32'h0, 0);
    cyc(10);
    for (i = 0; i < 4; i++)
      rd(8'h07 + i[7:0], 5 * (i + 1), 0);
    rst = 1;
    cyc(2);
    rst = 0;
    for (i = 0; i < 4; i++)
      rd(8'h07 + i[7:0], 5 * (i + 1), 0);
    wr(8'h07, 32'hffffffff, 1);
    rd(8'h04, 32'h0, 1);
    wr(8'h0b, 32'hffffffff, 1);
    rd(8'h0c, 32'h00010000, 0);
    wr(8'h0c, 32'h0, 1);
    give_verdict;
  end
endmodule // tsc_status_regs_bench
`default_nettype wire
